//--- rtl/rac_pkg.sv
/*
  Package for the alarm configuration block: register offsets, field layout,
  reset values, interval codes and the carrier structs.
  Assumes a 32-bit AXI4-Lite register bus and BCD time fields.
*/
package rac_pkg;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] RAC_OFS_CFG    = 8'h00;
  localparam logic [7:0] RAC_OFS_WINDOW = 8'h04;
  localparam logic [7:0] RAC_OFS_STATUS = 8'h08;
  localparam logic [7:0] RAC_OFS_MASK   = 8'h0c;

  // Register select codes
  localparam logic [2:0] RAC_SEL_CFG    = 3'h0;
  localparam logic [2:0] RAC_SEL_WINDOW = 3'h1;
  localparam logic [2:0] RAC_SEL_STATUS = 3'h2;
  localparam logic [2:0] RAC_SEL_MASK   = 3'h3;
  localparam logic [2:0] RAC_SEL_NONE   = 3'h4;

  // ----------------------------------------------------------------------
  // Reset values and implemented bits
  // ----------------------------------------------------------------------
  localparam logic [15:0] RAC_CFG_RESET  = 16'h0000;
  localparam logic [15:0] RAC_VAL_RESET  = 16'h0000;
  localparam logic [0:0]  RAC_STS_RESET  = 1'h0;
  localparam logic [0:0]  RAC_MSK_RESET  = 1'h0;
  localparam logic [15:0] RAC_MASK_MINSEC = 16'h7f7f;
  localparam logic [15:0] RAC_MASK_WDHR   = 16'h073f;
  localparam logic [15:0] RAC_MASK_MTHDY  = 16'h1f3f;

  // Window pointer values
  localparam logic [1:0] RAC_PTR_MINSEC = 2'h0;
  localparam logic [1:0] RAC_PTR_WDHR   = 2'h1;
  localparam logic [1:0] RAC_PTR_MTHDY  = 2'h2;
  localparam logic [1:0] RAC_PTR_NONE   = 2'h3;

  // Repeat counter limits
  localparam logic [7:0] RAC_RPT_ZERO = 8'h00;
  localparam logic [7:0] RAC_RPT_WRAP = 8'hff;

  // ----------------------------------------------------------------------
  // Interval codes
  // ----------------------------------------------------------------------
  localparam logic [3:0] RAC_IVL_HALF_SEC = 4'h0;
  localparam logic [3:0] RAC_IVL_SEC      = 4'h1;
  localparam logic [3:0] RAC_IVL_10SEC    = 4'h2;
  localparam logic [3:0] RAC_IVL_MIN      = 4'h3;
  localparam logic [3:0] RAC_IVL_10MIN    = 4'h4;
  localparam logic [3:0] RAC_IVL_HOUR     = 4'h5;
  localparam logic [3:0] RAC_IVL_DAY      = 4'h6;
  localparam logic [3:0] RAC_IVL_WEEK     = 4'h7;
  localparam logic [3:0] RAC_IVL_MONTH    = 4'h8;
  localparam logic [3:0] RAC_IVL_YEAR     = 4'h9;

  // AXI responses
  localparam logic [1:0] RAC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] RAC_RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // Carrier structs
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       alarm_on;
    logic       repeat_rollover_enable;
    logic [3:0] alarm_interval_select;
    logic [1:0] alarm_window_pointer;
    logic [7:0] alarm_repeat_count;
  } rac_cfg_type;

  typedef struct packed {
    logic [7:0] month;
    logic [7:0] day;
    logic [7:0] weekday;
    logic [7:0] hours;
    logic [7:0] minutes;
    logic [7:0] seconds;
  } rac_time_type;

endpackage

//--- rtl/rac_match.sv
/*
  Alarm compare: decides whether the current time tick matches the
  programmed alarm under the selected interval.
  Assumes time and alarm values in BCD; purely combinational.
*/
`timescale 1ns/1ps
module rac_match (
  input  wire logic               half_tick,
  input  wire logic               second_start,
  input  wire logic [3:0]         interval,
  input  wire rac_pkg::rac_time_type now,
  input  wire rac_pkg::rac_time_type alarm,
  output logic                    hit
);
  import rac_pkg::*;

  logic sec_ok;
  logic min_ok;
  logic hr_ok;
  logic new_sec;

  // ----------------------------------------------------------------------
  // Field compares
  // ----------------------------------------------------------------------
  assign new_sec = half_tick && second_start;
  assign sec_ok  = (now.seconds == alarm.seconds);
  assign min_ok  = (now.minutes == alarm.minutes) && sec_ok;
  assign hr_ok   = (now.hours == alarm.hours) && min_ok;

  // Interval selects which fields must agree
  always_comb begin
    unique case (interval)
      RAC_IVL_HALF_SEC: hit = half_tick;
      RAC_IVL_SEC:      hit = new_sec;
      RAC_IVL_10SEC:    hit = new_sec && (now.seconds[3:0] == alarm.seconds[3:0]);
      RAC_IVL_MIN:      hit = new_sec && sec_ok;
      RAC_IVL_10MIN:    hit = new_sec && sec_ok
                              && (now.minutes[3:0] == alarm.minutes[3:0]);
      RAC_IVL_HOUR:     hit = new_sec && min_ok;
      RAC_IVL_DAY:      hit = new_sec && hr_ok;
      RAC_IVL_WEEK:     hit = new_sec && hr_ok && (now.weekday == alarm.weekday);
      RAC_IVL_MONTH:    hit = new_sec && hr_ok && (now.day == alarm.day);
      // A 29 February date only exists in leap years: once in four years
      RAC_IVL_YEAR:     hit = new_sec && hr_ok && (now.day == alarm.day)
                              && (now.month == alarm.month);
      default:          hit = 1'b0;
    endcase
  end

endmodule

//--- rtl/rac_top.sv
/*
  Alarm configuration and repeat control with AXI4-Lite register access,
  alarm value window, repeat counter and a maskable interrupt.
  Assumes the time counter runs on aclk and supplies BCD time, a one-cycle
  half-second tick and a flag marking ticks that begin a new second.
*/
`timescale 1ns/1ps
module rac_top (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  clk_en,
  // AXI4-Lite slave
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Time counter side
  input  wire logic                  half_tick,
  input  wire logic                  second_start,
  input  wire rac_pkg::rac_time_type now,
  // Alarm outputs
  output logic                       alarm_pulse,
  output logic                       irq
);
  import rac_pkg::*;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [2:0] rac_decode(input logic [7:0] addr);
    unique case (addr)
      RAC_OFS_CFG:    rac_decode = RAC_SEL_CFG;
      RAC_OFS_WINDOW: rac_decode = RAC_SEL_WINDOW;
      RAC_OFS_STATUS: rac_decode = RAC_SEL_STATUS;
      RAC_OFS_MASK:   rac_decode = RAC_SEL_MASK;
      default:        rac_decode = RAC_SEL_NONE;
    endcase
  endfunction

  function automatic logic [15:0] rac_val_mask(input logic [1:0] ptr);
    unique case (ptr)
      RAC_PTR_MINSEC: rac_val_mask = RAC_MASK_MINSEC;
      RAC_PTR_WDHR:   rac_val_mask = RAC_MASK_WDHR;
      RAC_PTR_MTHDY:  rac_val_mask = RAC_MASK_MTHDY;
      default:        rac_val_mask = 16'h0000;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  rac_cfg_type  cfg_q,   cfg_d;
  logic [15:0]  vals_q [3];
  logic [15:0]  vals_d [3];
  logic         sts_q,   sts_d;
  logic         msk_q,   msk_d;
  logic         bvalid_q, bvalid_d;
  logic [1:0]   bresp_q, bresp_d;
  logic         rvalid_q, rvalid_d;
  logic [1:0]   rresp_q, rresp_d;
  logic [31:0]  rdata_q, rdata_d;
  logic         pulse_q, pulse_d;

  logic         wr_go;
  logic         rd_go;
  logic [2:0]   wr_sel;
  logic [2:0]   rd_sel;
  logic         hit;
  logic         alarm_event;
  logic [15:0]  window_val;
  logic [15:0]  val_mask;
  rac_time_type alarm_time;

  // ----------------------------------------------------------------------
  // Bus handshakes
  // ----------------------------------------------------------------------
  // Address and data are taken together, one write and one read at a time
  assign wr_go         = clk_en && s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  assign rd_go         = clk_en && s_axi_arvalid && !rvalid_q;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = rd_go;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;
  assign wr_sel        = rac_decode(s_axi_awaddr);
  assign rd_sel        = rac_decode(s_axi_araddr);
  assign alarm_pulse   = pulse_q;
  assign irq           = sts_q && msk_q;

  // ----------------------------------------------------------------------
  // Alarm match
  // ----------------------------------------------------------------------
  // Alarm values laid out as the time struct for the compare
  assign alarm_time.month   = {3'h0, vals_q[RAC_PTR_MTHDY][12:8]};
  assign alarm_time.day     = {2'h0, vals_q[RAC_PTR_MTHDY][5:0]};
  assign alarm_time.weekday = {5'h00, vals_q[RAC_PTR_WDHR][10:8]};
  assign alarm_time.hours   = {2'h0, vals_q[RAC_PTR_WDHR][5:0]};
  assign alarm_time.minutes = {1'h0, vals_q[RAC_PTR_MINSEC][14:8]};
  assign alarm_time.seconds = {1'h0, vals_q[RAC_PTR_MINSEC][6:0]};

  rac_match u_match (
    .half_tick    (half_tick),
    .second_start (second_start),
    .interval     (cfg_q.alarm_interval_select),
    .now          (now),
    .alarm        (alarm_time),
    .hit          (hit)
  );

  assign alarm_event = clk_en && cfg_q.alarm_on && hit;

  // Implemented bits of the pair at the pointer
  assign val_mask = rac_val_mask(cfg_q.alarm_window_pointer);

  // Window contents at the current pointer
  always_comb begin
    if (cfg_q.alarm_window_pointer == RAC_PTR_NONE) begin
      window_val = 16'h0000;
    end else begin
      window_val = vals_q[cfg_q.alarm_window_pointer];
    end
  end

  // ----------------------------------------------------------------------
  // Next-state logic for registers and bus answers
  // ----------------------------------------------------------------------
  always_comb begin
    cfg_d    = cfg_q;
    vals_d   = vals_q;
    sts_d    = sts_q;
    msk_d    = msk_q;
    bvalid_d = bvalid_q;
    bresp_d  = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d  = rresp_q;
    rdata_d  = rdata_q;
    pulse_d  = alarm_event;

    // Repeat handling on each alarm event
    if (alarm_event) begin
      if (cfg_q.alarm_repeat_count == RAC_RPT_ZERO) begin
        if (cfg_q.repeat_rollover_enable) begin
          cfg_d.alarm_repeat_count = RAC_RPT_WRAP;
        end else begin
          cfg_d.alarm_on = 1'b0;
        end
      end else begin
        cfg_d.alarm_repeat_count = cfg_q.alarm_repeat_count - 8'h01;
      end
    end

    // Response channels close on their handshake
    if (bvalid_q && s_axi_bready && clk_en) begin
      bvalid_d = 1'b0;
    end
    if (rvalid_q && s_axi_rready && clk_en) begin
      rvalid_d = 1'b0;
    end

    // Register writes, software CFG bytes override the event update
    if (wr_go) begin
      bvalid_d = 1'b1;
      bresp_d  = (wr_sel == RAC_SEL_NONE) ? RAC_RESP_SLVERR : RAC_RESP_OKAY;
      unique case (wr_sel)
        RAC_SEL_CFG: begin
          if (s_axi_wstrb[0]) begin
            cfg_d.alarm_repeat_count = s_axi_wdata[7:0];
          end
          if (s_axi_wstrb[1]) begin
            cfg_d.alarm_on               = s_axi_wdata[15];
            cfg_d.repeat_rollover_enable = s_axi_wdata[14];
            cfg_d.alarm_interval_select  = s_axi_wdata[13:10];
            cfg_d.alarm_window_pointer   = s_axi_wdata[9:8];
          end
        end
        RAC_SEL_WINDOW: begin
          if (cfg_q.alarm_window_pointer != RAC_PTR_NONE) begin
            if (s_axi_wstrb[0]) begin
              vals_d[cfg_q.alarm_window_pointer][7:0] = s_axi_wdata[7:0]
                & val_mask[7:0];
            end
            if (s_axi_wstrb[1]) begin
              vals_d[cfg_q.alarm_window_pointer][15:8] = s_axi_wdata[15:8]
                & val_mask[15:8];
            end
          end
          if (s_axi_wstrb[1] && cfg_q.alarm_window_pointer != RAC_PTR_MINSEC) begin
            cfg_d.alarm_window_pointer = cfg_q.alarm_window_pointer - 2'h1;
          end
        end
        RAC_SEL_STATUS: begin
          if (s_axi_wstrb[0] && s_axi_wdata[0]) begin
            sts_d = 1'b0;
          end
        end
        RAC_SEL_MASK: begin
          if (s_axi_wstrb[0]) begin
            msk_d = s_axi_wdata[0];
          end
        end
        default: begin
        end
      endcase
    end

    // Register reads; a window read also steps the pointer down, holding at MINSEC
    if (rd_go) begin
      rvalid_d = 1'b1;
      rresp_d  = (rd_sel == RAC_SEL_NONE) ? RAC_RESP_SLVERR : RAC_RESP_OKAY;
      unique case (rd_sel)
        RAC_SEL_CFG:    rdata_d = {16'h0000, cfg_q};
        RAC_SEL_WINDOW: begin
          rdata_d = {16'h0000, window_val};
          if (cfg_q.alarm_window_pointer != RAC_PTR_MINSEC &&
              !(wr_go && wr_sel == RAC_SEL_WINDOW && s_axi_wstrb[1])) begin
            cfg_d.alarm_window_pointer = cfg_q.alarm_window_pointer - 2'h1;
          end
        end
        RAC_SEL_STATUS: rdata_d = {31'h00000000, sts_q};
        RAC_SEL_MASK:   rdata_d = {31'h00000000, msk_q};
        default:        rdata_d = 32'h00000000;
      endcase
    end

    // Event sets the sticky flag, winning over a clear
    if (alarm_event) begin
      sts_d = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q    <= RAC_CFG_RESET;
      vals_q   <= '{RAC_VAL_RESET, RAC_VAL_RESET, RAC_VAL_RESET};
      sts_q    <= RAC_STS_RESET;
      msk_q    <= RAC_MSK_RESET;
      bvalid_q <= 1'b0;
      bresp_q  <= RAC_RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q  <= RAC_RESP_OKAY;
      rdata_q  <= 32'h00000000;
      pulse_q  <= 1'b0;
    end else if (clk_en) begin
      cfg_q    <= cfg_d;
      vals_q   <= vals_d;
      sts_q    <= sts_d;
      msk_q    <= msk_d;
      bvalid_q <= bvalid_d;
      bresp_q  <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q  <= rresp_d;
      rdata_q  <= rdata_d;
      pulse_q  <= pulse_d;
    end
  end

endmodule

//--- sim/rac_top_asserts.sv
/*
  Checker for the alarm configuration block: bus answers, alarm timing, irq.
  Assumes binding to rac_top; interval and mask are shadowed from bus writes.
*/
`timescale 1ns/1ps
module rac_top_asserts (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        half_tick,
  input wire logic        second_start,
  input wire logic        alarm_pulse,
  input wire logic        irq
);
  import rac_pkg::*;
  logic [3:0] ivl_q;
  logic [3:0] ivl_d;
  logic       mask_q;
  logic       mask_d;
  logic       wr_take;

  // ----------------------------------------------------------------------
  // Shadow of interval and mask
  // ----------------------------------------------------------------------
  assign wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

  // Next values from accepted writes
  always_comb begin
    ivl_d = ivl_q;
    mask_d = mask_q;
    if (wr_take && s_axi_awaddr == RAC_OFS_CFG && s_axi_wstrb[1]) begin
      ivl_d = s_axi_wdata[13:10];
    end
    if (wr_take && s_axi_awaddr == RAC_OFS_MASK && s_axi_wstrb[0]) begin
      mask_d = s_axi_wdata[0];
    end
  end

  // Register the shadow
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ivl_q <= 4'h0;
      mask_q <= 1'b0;
    end else begin
      ivl_q <= ivl_d;
      mask_q <= mask_d;
    end
  end

  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_write_answer: assert property (wr_take |=> s_axi_bvalid)
    else $error("write taken without response");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read taken without response");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_unmapped_err: assert property (wr_take && s_axi_awaddr > RAC_OFS_MASK |=>
    s_axi_bresp == RAC_RESP_SLVERR) else $error("unmapped write not refused");
  a_pulse_cause: assert property ($rose(alarm_pulse) |-> $past(half_tick))
    else $error("alarm without half-second tick");
  a_whole_second: assert property (
    half_tick && ivl_q != RAC_IVL_HALF_SEC && !second_start |=> !alarm_pulse)
    else $error("alarm on a mid-second tick");
  a_reserved_quiet: assert property (
    half_tick && ivl_q > RAC_IVL_YEAR |=> !alarm_pulse)
    else $error("alarm under a reserved interval code");
  a_irq_raise: assert property (alarm_pulse && mask_q |-> ##[0:1] irq)
    else $error("unmasked alarm gave no interrupt");
  a_irq_masked: assert property (!mask_q && !$past(mask_q) |-> !irq)
    else $error("interrupt while masked");
endmodule

//--- sim/tb.sv
/*
  Self-checking bench for rac_top: registers, window, intervals, repeats, irq.
  Assumes rac_top and rac_pkg compiled first; bench drives the time side.
*/
`timescale 1ns/1ps
module tb;
  import rac_pkg::*;
  localparam rac_time_type T_MATCH = {8'h02, 8'h29, 8'h05, 8'h23, 8'h59, 8'h30};
  logic         aclk, aresetn, clk_en, half_tick, second_start;
  logic [7:0]   awaddr, araddr;
  logic         awvalid, awready, wvalid, wready, bvalid, bready;
  logic         arvalid, arready, rvalid, rready, alarm_pulse, irq;
  logic [31:0]  wdata, rdata;
  logic [3:0]   wstrb;
  logic [1:0]   bresp, rresp;
  rac_time_type now;
  int           errors, tests_run;

  rac_top u_rac_top (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .half_tick(half_tick), .second_start(second_start), .now(now),
    .alarm_pulse(alarm_pulse), .irq(irq));

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Write with one stall cycle before the response is accepted
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(posedge aclk); while (!(awready && wready));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    while (!bvalid) @(posedge aclk);
    bready <= 1'b1;
    @(posedge aclk);
    check({30'h0, bresp}, {30'h0, (a > RAC_OFS_MASK) ? RAC_RESP_SLVERR : RAC_RESP_OKAY});
    bready <= 1'b0;
  endtask

  // Read with one stall cycle, then compare data and response
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    rready <= 1'b1;
    @(posedge aclk);
    check(rdata, exp);
    check({30'h0, rresp}, {30'h0, (a > RAC_OFS_MASK) ? RAC_RESP_SLVERR : RAC_RESP_OKAY});
    rready <= 1'b0;
  endtask

  // One half-second tick, then look for the alarm pulse
  task automatic tick(input logic ss, input rac_time_type t, input logic exp);
    @(posedge aclk);
    half_tick <= 1'b1;
    second_start <= ss;
    now <= t;
    @(posedge aclk);
    half_tick <= 1'b0;
    #1;
    check({31'h0, alarm_pulse}, {31'h0, exp});
  endtask

  function automatic logic [31:0] cfg(input logic on, input logic roll, input logic [3:0] c,
                                      input logic [1:0] p, input logic [7:0] n);
    return {16'h0, on, roll, c, p, n};
  endfunction

  // Time that differs from the alarm in the coarsest field of a code
  function automatic rac_time_type miss(input logic [3:0] c);
    rac_time_type t;
    t = T_MATCH;
    case (c)
      4'h2: t.seconds = 8'h31;
      4'h3: t.seconds = 8'h20;
      4'h4: t.minutes = 8'h58;
      4'h5: t.minutes = 8'h49;
      4'h6: t.hours = 8'h22;
      4'h7: t.weekday = 8'h04;
      4'h8: t.day = 8'h28;
      default: t.month = 8'h03;
    endcase
    return t;
  endfunction

  // ----------------------------------------------------------------------
  // Clock, watchdog and sequence
  // ----------------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  initial begin
    #500000;
    errors++;
    conclude();
  end

  initial begin
    errors = 0;
    tests_run = 0;
    {aresetn, half_tick, second_start, awvalid, wvalid, bready, arvalid, rready} = 8'h00;
    clk_en = 1'b1;
    now = '0;
    {awaddr, araddr, wstrb} = 20'h0;
    wdata = 32'h0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(RAC_OFS_CFG, 32'h0);
    rd(RAC_OFS_STATUS, 32'h0);
    rd(RAC_OFS_MASK, 32'h0);
    rd(8'h10, 32'h0);
    wr(8'h10, 32'hffff, 4'hf);
    // Fill the window from pointer 10 downwards
    wr(RAC_OFS_CFG, cfg(0, 0, 0, RAC_PTR_MTHDY, 0), 4'h3);
    wr(RAC_OFS_WINDOW, 32'h0229, 4'h3);
    rd(RAC_OFS_CFG, cfg(0, 0, 0, RAC_PTR_WDHR, 0));
    wr(RAC_OFS_WINDOW, 32'h0523, 4'h3);
    wr(RAC_OFS_WINDOW, 32'h5930, 4'h3);
    rd(RAC_OFS_CFG, 32'h0);
    rd(RAC_OFS_WINDOW, 32'h5930);
    rd(RAC_OFS_WINDOW, 32'h5930);
    wr(RAC_OFS_CFG, cfg(0, 0, 0, RAC_PTR_NONE, 0), 4'h3);
    rd(RAC_OFS_WINDOW, 32'h0);
    rd(RAC_OFS_WINDOW, 32'h0229);
    rd(RAC_OFS_WINDOW, 32'h0523);
    rd(RAC_OFS_CFG, 32'h0);
    // Every interval code on a matching time, codes 1 to 9 also on a missing one
    for (int c = 0; c < 16; c++) begin
      wr(RAC_OFS_CFG, cfg(1, 1, c[3:0], RAC_PTR_MINSEC, 8'hff), 4'h3);
      tick(c != 0, T_MATCH, c < 10);
      if (c > 0 && c < 10) begin
        tick(c != 1, miss(c[3:0]), 1'b0);
      end
    end
    // Repeat count runs out and the alarm switches itself off
    wr(RAC_OFS_CFG, cfg(1, 0, RAC_IVL_HALF_SEC, 0, 8'h02), 4'h3);
    tick(1'b0, T_MATCH, 1'b1);
    rd(RAC_OFS_CFG, cfg(1, 0, 0, 0, 8'h01));
    tick(1'b0, T_MATCH, 1'b1);
    tick(1'b0, T_MATCH, 1'b1);
    rd(RAC_OFS_CFG, 32'h0);
    tick(1'b0, T_MATCH, 1'b0);
    // Rollover wraps the count instead
    wr(RAC_OFS_CFG, cfg(1, 1, 0, 0, 8'h00), 4'h3);
    tick(1'b0, T_MATCH, 1'b1);
    rd(RAC_OFS_CFG, cfg(1, 1, 0, 0, 8'hff));
    // Interrupt: sticky status, mask, write-one clear
    check({31'h0, irq}, 32'h0);
    wr(RAC_OFS_MASK, 32'h1, 4'h1);
    #1 check({31'h0, irq}, 32'h1);
    wr(RAC_OFS_STATUS, 32'h1, 4'h1);
    rd(RAC_OFS_STATUS, 32'h0);
    check({31'h0, irq}, 32'h0);
    tick(1'b0, T_MATCH, 1'b1);
    rd(RAC_OFS_STATUS, 32'h1);
    check({31'h0, irq}, 32'h1);
    wr(RAC_OFS_STATUS, 32'h1, 4'h1);
    // Clock enable low freezes the alarm
    @(posedge aclk);
    clk_en <= 1'b0;
    tick(1'b0, T_MATCH, 1'b0);
    @(posedge aclk);
    clk_en <= 1'b1;
    // Frozen tick must not have set the status flag
    rd(RAC_OFS_STATUS, 32'h0);
    conclude();
  end
endmodule

bind rac_top rac_top_asserts u_rac_top_asserts (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .half_tick(half_tick), .second_start(second_start), .alarm_pulse(alarm_pulse), .irq(irq));
